// *** rtl/reset_config_latch.sv ***
// reset strap capture, first bus configuration and register port
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
// What this block does
// RL1: bus-type bits of first bus config load from port bits 7:6 at sequence end.
// RL2: external-access pin high during reset clears first bus config to zero.
// RL3: pin low sets bus-active and latch-lengthen bits and loads bus type.
// RL4: write-config 0 makes write pins byte strobes; 1 keeps normal roles.
// RL5: chip-select code sets active lines: 3, 2, none, or 5 (default).
// RL6: segment code sets address lines: 4, none, 8, or 2 (default).
// RL7: clock code picks multiplier: 16, half, 10, 1, 5.
// RL8: strap register is read-only; writes change nothing.
// RL9: every reset captures write-config, chip-select and segment fields.
// RL10: clock field recaptured only on long hardware reset, else kept.
// RL11: pull-ups on upper port during reset; unstrapped reads all ones.
// RL12: bus type: 8-bit demux, 8-bit mux, 16-bit demux, 16-bit mux.
// RL13: layout: bit0 write, 2:1 cs, 4:3 seg, 7:5 clock, 15:8 zero.
// RL14: clock codes 101, 110, 111 give 8, 8 and 4 times.
module reset_config_latch
   import reset_config_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic rst_seq,
   input wire logic long_rst,
   input wire logic [15:0] configuration_port,
   input wire logic external_access_pin,
   input wire logic wr_strobe_b,
   input wire logic byte_high_strobe_b,
   input wire logic low_byte_write_strobe_b,
   input wire logic high_byte_write_strobe_b,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [15:0] rdata,
   output logic cfg_pullup_en,
   output logic write_pin_b,
   output logic byte_high_enable_pin_b,
   output logic [4:0] chip_select_en,
   output logic [7:0] segment_line_en,
   output logic [5:0] clk_mult_x2,
   output logic bus_is_16bit,
   output logic bus_is_muxed,
   output logic [7:0] reset_strap_config,
   output logic [15:0] first_bus_config_reg
);
   // ==========================================
   // pin synchronisers
   logic [15:0] port_s;
   logic ext_access_s;
   logic [7:0] strap_pins;
   logic [1:0] bus_type_pins;

   pin_sync #(.WIDTH(16), .INIT(16'hffff)) u_port_sync (
      .clk(clk),
      .rst_b(rst_b),
      .pin(configuration_port),
      .level(port_s)
   );

   pin_sync #(.WIDTH(1), .INIT(1'h1)) u_access_sync (
      .clk(clk),
      .rst_b(rst_b),
      .pin(external_access_pin),
      .level(ext_access_s)
   );

   assign strap_pins = port_s[PORT_STRAP_LSB +: 8];
   assign bus_type_pins = port_s[PORT_TYPE_LSB +: 2];

   // ==========================================
   // reset sequence tracking
   typedef enum logic [1:0] {
      SEQ_SETTLE,
      SEQ_ACTIVE,
      SEQ_RUN
   } seq_state_type;

   seq_state_type state_q;
   seq_state_type state_d;
   logic [1:0] settle_q;
   logic por_q;
   logic seq_end;
   logic capture_long;

   // power-on waits for the synchronisers to fill before capture
   always_comb begin
      state_d = state_q;
      case (state_q)
         SEQ_SETTLE: begin
            if (rst_seq) begin
               state_d = SEQ_ACTIVE;
            end else if (settle_q == SYNC_SETTLE) begin
               state_d = SEQ_RUN;
            end
         end
         SEQ_ACTIVE: begin
            if (!rst_seq) begin
               state_d = SEQ_RUN;
            end
         end
         SEQ_RUN: begin
            if (rst_seq) begin
               state_d = SEQ_ACTIVE;
            end
         end
         default: state_d = SEQ_SETTLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= SEQ_SETTLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         settle_q <= 2'h0;
      end else if (state_q == SEQ_SETTLE && settle_q != SYNC_SETTLE) begin
         settle_q <= settle_q + 2'h1;
      end
   end

   // power-on counts as a long reset until the first capture
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         por_q <= 1'h1;
      end else if (seq_end) begin
         por_q <= 1'h0;
      end
   end

   assign seq_end = (state_q != SEQ_RUN) && (state_d == SEQ_RUN);
   assign capture_long = long_rst || por_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_pullup_en <= 1'h1;
      end else begin
         cfg_pullup_en <= (state_d != SEQ_RUN); // [RL11]
      end
   end

   // ==========================================
   // strap register
   // clock field survives short resets
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reset_strap_config <= STRAP_RESET;
      end else if (seq_end) begin
         reset_strap_config[CLK_LSB-1:0] <= strap_pins[CLK_LSB-1:0]; // [RL9] [RL13]
         if (capture_long) begin
            reset_strap_config[7:CLK_LSB] <= strap_pins[7:CLK_LSB]; // [RL10] [RL13]
         end
      end
   end

   // ==========================================
   // first bus configuration
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         first_bus_config_reg <= BUS_CFG_RESET;
      end else if (seq_end) begin
         if (ext_access_s) begin
            first_bus_config_reg <= BUS_CFG_RESET; // [RL2]
         end else begin
            first_bus_config_reg <= BUS_CFG_RESET;
            first_bus_config_reg[BUS_ACT_BIT] <= 1'h1; // [RL3]
            first_bus_config_reg[LATCH_LEN_BIT] <= 1'h1; // [RL3]
            first_bus_config_reg[BUS_TYPE_LSB +: 2] <= bus_type_pins; // [RL1] [RL3]
         end
      end else if (wr_en && addr == BUS_CFG_OFFSET) begin
         first_bus_config_reg <= wdata;
      end
   end

   // ==========================================
   // decode and registered outputs
   logic [4:0] cs_mask;
   logic [7:0] seg_mask;
   logic [5:0] mult_x2;
   logic bus16;
   logic muxed;

   strap_decode u_decode (
      .chip_select_count(reset_strap_config[CS_LSB +: 2]),
      .segment_line_count(reset_strap_config[SEG_LSB +: 2]),
      .clock_multiplier_select(reset_strap_config[CLK_LSB +: 3]),
      .bus_type_field(first_bus_config_reg[BUS_TYPE_LSB +: 2]),
      .cs_mask(cs_mask),
      .seg_mask(seg_mask),
      .mult_x2(mult_x2),
      .bus16(bus16),
      .muxed(muxed)
   );

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chip_select_en <= CS_MASK_11;
         segment_line_en <= SEG_MASK_11;
         clk_mult_x2 <= MULT2_111;
         bus_is_16bit <= 1'h0;
         bus_is_muxed <= 1'h0;
      end else begin
         chip_select_en <= cs_mask; // [RL5]
         segment_line_en <= seg_mask; // [RL6]
         clk_mult_x2 <= mult_x2; // [RL7]
         bus_is_16bit <= bus16; // [RL12]
         bus_is_muxed <= muxed; // [RL12]
      end
   end

   // write pin roles follow the write-config strap
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         write_pin_b <= 1'h1;
         byte_high_enable_pin_b <= 1'h1;
      end else if (!reset_strap_config[WCFG_BIT]) begin
         write_pin_b <= low_byte_write_strobe_b; // [RL4]
         byte_high_enable_pin_b <= high_byte_write_strobe_b; // [RL4]
      end else begin
         write_pin_b <= wr_strobe_b; // [RL4]
         byte_high_enable_pin_b <= byte_high_strobe_b; // [RL4]
      end
   end

   // ==========================================
   // register read port
   // strap writes fall through: no write path exists for it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= RDATA_IDLE;
      end else if (rd_en) begin
         case (addr)
            STRAP_CFG_OFFSET: rdata <= {8'h00, reset_strap_config}; // [RL8] [RL13]
            BUS_CFG_OFFSET: rdata <= first_bus_config_reg;
            default: rdata <= RDATA_IDLE;
         endcase
      end else begin
         rdata <= RDATA_IDLE;
      end
   end

   // ==========================================
   // assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   AST_BUS_TYPE_LOAD: assert property ( // [RL1]
      seq_end && !ext_access_s |=>
         first_bus_config_reg[BUS_TYPE_LSB +: 2] == $past(bus_type_pins))
      else $error("bus type not loaded from port");

   AST_BUS_CLEAR: assert property ( // [RL2]
      seq_end && ext_access_s |=> first_bus_config_reg == 16'h0000)
      else $error("first bus config not cleared");

   AST_BUS_ENABLE: assert property ( // [RL3]
      seq_end && !ext_access_s |=>
         first_bus_config_reg[BUS_ACT_BIT] && first_bus_config_reg[LATCH_LEN_BIT])
      else $error("bus active or latch bit not set");

   AST_WRITE_MUX: assert property ( // [RL4]
      !reset_strap_config[WCFG_BIT] |=>
         write_pin_b == $past(low_byte_write_strobe_b) &&
         byte_high_enable_pin_b == $past(high_byte_write_strobe_b))
      else $error("write pins not byte strobes");

   AST_WRITE_NORMAL: assert property ( // [RL4]
      reset_strap_config[WCFG_BIT] |=>
         write_pin_b == $past(wr_strobe_b) &&
         byte_high_enable_pin_b == $past(byte_high_strobe_b))
      else $error("write pins lost normal roles");

   AST_CS_COUNT: assert property ( // [RL5]
      reset_strap_config[CS_LSB +: 2] == 2'h3 ##1
         reset_strap_config[CS_LSB +: 2] == 2'h3 |-> chip_select_en == 5'h1f)
      else $error("chip select count wrong");

   // mask lags the strap field by exactly one registered stage
   AST_SEG_COUNT: assert property ( // [RL6]
      reset_strap_config[SEG_LSB +: 2] == 2'h2 |=> segment_line_en == 8'hff)
      else $error("segment line count wrong");

   AST_SEG_DEFAULT: assert property ( // [RL6]
      reset_strap_config[SEG_LSB +: 2] == 2'h3 |=> segment_line_en == 8'h03)
      else $error("default segment lines wrong");

   AST_CS_NONE: assert property ( // [RL5]
      reset_strap_config[CS_LSB +: 2] == 2'h2 |=> chip_select_en == 5'h00)
      else $error("chip select lines not all off");

   AST_CLK_MULT: assert property ( // [RL7]
      $stable(reset_strap_config) && reset_strap_config[CLK_LSB +: 3] == 3'h0
         |=> clk_mult_x2 == 6'h20)
      else $error("clock multiplier wrong");

   AST_READ_ONLY: assert property ( // [RL8]
      wr_en && addr == STRAP_CFG_OFFSET && !seq_end |=> $stable(reset_strap_config))
      else $error("strap register changed by write");

   AST_FIELD_CAPTURE: assert property ( // [RL9]
      seq_end |=> reset_strap_config[CLK_LSB-1:0] == $past(strap_pins[CLK_LSB-1:0]))
      else $error("strap fields not captured");

   AST_CLK_KEEP: assert property ( // [RL10]
      seq_end && !capture_long |=> $stable(reset_strap_config[7:CLK_LSB]))
      else $error("clock field changed on short reset");

   AST_PULLUP: assert property ( // [RL11]
      rst_seq |=> cfg_pullup_en)
      else $error("pull-ups off during reset");

   AST_BUS_DECODE: assert property ( // [RL12]
      first_bus_config_reg[BUS_TYPE_LSB +: 2] == 2'h3 |=> bus_is_16bit && bus_is_muxed)
      else $error("bus type decode wrong");

   AST_LAYOUT: assert property ( // [RL13]
      rd_en && addr == STRAP_CFG_OFFSET |=>
         rdata == {8'h00, $past(reset_strap_config)})
      else $error("strap read data wrong");

   AST_CLK_UPPER: assert property ( // [RL14]
      $stable(reset_strap_config) && reset_strap_config[CLK_LSB +: 3] == 3'h7
         |=> clk_mult_x2 == 6'h08)
      else $error("upper clock code wrong");

   AST_CLK_HALF: assert property ( // [RL7]
      reset_strap_config[CLK_LSB +: 3] == 3'h1 |=> clk_mult_x2 == 6'h01)
      else $error("half clock multiplier wrong");

   AST_PULLUP_DROP: assert property ( // [RL11]
      seq_end |=> !cfg_pullup_en)
      else $error("pull-ups still on after capture");

   AST_RDATA_IDLE: assert property ( // [RL13]
      !rd_en |=> rdata == RDATA_IDLE)
      else $error("read data not idle");

   COV_LONG_CAPTURE: cover property (seq_end && long_rst);
   COV_SHORT_CAPTURE: cover property (seq_end && !long_rst && !por_q);
   COV_EXTERNAL_BOOT: cover property (seq_end && !ext_access_s);
   COV_STRAP_READ: cover property (rd_en && addr == STRAP_CFG_OFFSET);
endmodule

// *** rtl/reset_config_pkg.sv ***
// constants for the reset strap capture block
package reset_config_pkg;
   // ==========================================
   // register map
   localparam logic [15:0] STRAP_CFG_OFFSET = 16'hf108;
   localparam logic [15:0] BUS_CFG_OFFSET = 16'hf10c;
   localparam logic [7:0] STRAP_RESET = 8'hff;
   localparam logic [15:0] BUS_CFG_RESET = 16'h0000;
   localparam logic [15:0] RDATA_IDLE = 16'h0000;
   // ==========================================
   // field positions
   localparam int WCFG_BIT = 0;
   localparam int CS_LSB = 1;
   localparam int SEG_LSB = 3;
   localparam int CLK_LSB = 5;
   localparam int BUS_TYPE_LSB = 6;
   localparam int LATCH_LEN_BIT = 9;
   localparam int BUS_ACT_BIT = 10;
   localparam int PORT_STRAP_LSB = 8;
   localparam int PORT_TYPE_LSB = 6;
   // ==========================================
   // timing
   localparam logic [1:0] SYNC_SETTLE = 2'h2;
   // ==========================================
   // decode tables
   localparam logic [4:0] CS_MASK_00 = 5'h07;
   localparam logic [4:0] CS_MASK_01 = 5'h03;
   localparam logic [4:0] CS_MASK_10 = 5'h00;
   localparam logic [4:0] CS_MASK_11 = 5'h1f;
   localparam logic [7:0] SEG_MASK_00 = 8'h0f;
   localparam logic [7:0] SEG_MASK_01 = 8'h00;
   localparam logic [7:0] SEG_MASK_10 = 8'hff;
   localparam logic [7:0] SEG_MASK_11 = 8'h03;
   // multiplier held as twice its value so that one half fits
   localparam logic [5:0] MULT2_000 = 6'h20;
   localparam logic [5:0] MULT2_001 = 6'h01;
   localparam logic [5:0] MULT2_010 = 6'h14;
   localparam logic [5:0] MULT2_011 = 6'h02;
   localparam logic [5:0] MULT2_100 = 6'h0a;
   localparam logic [5:0] MULT2_101 = 6'h10;
   localparam logic [5:0] MULT2_110 = 6'h10;
   localparam logic [5:0] MULT2_111 = 6'h08;
endpackage

// *** rtl/pin_sync.sv ***
// two-stage synchroniser for a group of pins
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] meta_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= INIT;
         level <= INIT;
      end else begin
         meta_q <= pin;
         level <= meta_q;
      end
   end
endmodule

// *** rtl/strap_decode.sv ***
// decodes captured strap fields into line masks and clock ratio
`timescale 1ns/10ps
module strap_decode
   import reset_config_pkg::*;
(
   input wire logic [1:0] chip_select_count,
   input wire logic [1:0] segment_line_count,
   input wire logic [2:0] clock_multiplier_select,
   input wire logic [1:0] bus_type_field,
   output logic [4:0] cs_mask,
   output logic [7:0] seg_mask,
   output logic [5:0] mult_x2,
   output logic bus16,
   output logic muxed
);
   always_comb begin
      case (chip_select_count) // [RL5]
         2'h0: cs_mask = CS_MASK_00;
         2'h1: cs_mask = CS_MASK_01;
         2'h2: cs_mask = CS_MASK_10;
         default: cs_mask = CS_MASK_11;
      endcase
   end
   always_comb begin
      case (segment_line_count) // [RL6]
         2'h0: seg_mask = SEG_MASK_00;
         2'h1: seg_mask = SEG_MASK_01;
         2'h2: seg_mask = SEG_MASK_10;
         default: seg_mask = SEG_MASK_11;
      endcase
   end
   always_comb begin
      case (clock_multiplier_select) // [RL7]
         3'h0: mult_x2 = MULT2_000;
         3'h1: mult_x2 = MULT2_001;
         3'h2: mult_x2 = MULT2_010;
         3'h3: mult_x2 = MULT2_011;
         3'h4: mult_x2 = MULT2_100;
         3'h5: mult_x2 = MULT2_101; // [RL14]
         3'h6: mult_x2 = MULT2_110; // [RL14]
         default: mult_x2 = MULT2_111; // [RL14]
      endcase
   end
   // upper bit is width, lower bit is multiplexing
   always_comb begin
      bus16 = bus_type_field[1]; // [RL12]
      muxed = bus_type_field[0]; // [RL12]
   end
endmodule

// *** testbench/board_strap_model.sv ***
// board strapping model for the configuration port
`timescale 1ns/10ps
module board_strap_model (
   input wire logic clk,
   input wire logic [15:0] pd_mask,
   input wire logic pullup_en,
   output logic [15:0] port_level
);
   // ==========================================
   // released lines
   // once the pull-ups drop the port carries bus traffic, so never hold the straps
   logic [15:0] float_q = 16'h5a5a;
   always_ff @(posedge clk) begin
      float_q <= ~float_q;
   end
   // ==========================================
   // strap resolution
   // unstrapped pins read one while pulled up, a fitted pull-down reads zero
   assign port_level = pullup_en ? ~pd_mask : float_q;
endmodule

// *** testbench/reset_config_latch_tb.sv ***
// self-checking bench for the reset strap capture block
`timescale 1ns/10ps
module reset_config_latch_tb;
   import reset_config_pkg::*;
   // ==========================================
   // signals
   logic clk = 1'b0;
   logic rst_b, rst_seq, long_rst, external_access_pin, wr_en, rd_en, rd_seen;
   logic wr_strobe_b, byte_hi_b, low_b, high_b;
   logic [15:0] configuration_port, addr, wdata, rdata, pd_mask, first_bus_config_reg, w;
   logic cfg_pullup_en, write_pin_b, byte_high_enable_pin_b, bus_is_16bit, bus_is_muxed;
   logic [4:0] chip_select_en;
   logic [7:0] segment_line_en, reset_strap_config, s, exp_s;
   logic [5:0] clk_mult_x2;
   logic [1:0] bt;
   logic [2:0] c;
   logic [3:0] st;
   logic [15:0] exp_q[$];
   int num_errors = 0;
   int tests_run = 0;
   localparam logic [4:0] cs_tab [4] = '{5'h07, 5'h03, 5'h00, 5'h1f};
   localparam logic [7:0] seg_tab [4] = '{8'h0f, 8'h00, 8'hff, 8'h03};
   localparam logic [5:0] mult_tab [8] = '{6'h20, 6'h01, 6'h14, 6'h02, 6'h0a, 6'h10, 6'h10, 6'h08};
   always #12.5 clk = ~clk;
   // ==========================================
   // instances
   reset_config_latch i_reset_config_latch (.clk(clk), .rst_b(rst_b), .rst_seq(rst_seq),
      .long_rst(long_rst), .configuration_port(configuration_port),
      .external_access_pin(external_access_pin), .wr_strobe_b(wr_strobe_b),
      .byte_high_strobe_b(byte_hi_b), .low_byte_write_strobe_b(low_b),
      .high_byte_write_strobe_b(high_b), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cfg_pullup_en(cfg_pullup_en),
      .write_pin_b(write_pin_b), .byte_high_enable_pin_b(byte_high_enable_pin_b),
      .chip_select_en(chip_select_en), .segment_line_en(segment_line_en),
      .clk_mult_x2(clk_mult_x2), .bus_is_16bit(bus_is_16bit), .bus_is_muxed(bus_is_muxed),
      .reset_strap_config(reset_strap_config), .first_bus_config_reg(first_bus_config_reg));
   board_strap_model i_board_strap_model (.clk(clk), .pd_mask(pd_mask),
      .pullup_en(cfg_pullup_en), .port_level(configuration_port));
   // ==========================================
   // tasks
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // one bus cycle per call, so back-to-back calls never drive a strobe twice per edge
   task automatic acc(input logic wr, input logic rd, input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      wr_en <= wr;
      rd_en <= rd;
      addr <= a;
      wdata <= d;
      if (rd) begin
         exp_q.push_back(d);
      end
   endtask
   task automatic check_cfg(input logic [7:0] es, input logic [15:0] eb);
      chk("strap", 16'(es), 16'(reset_strap_config));
      chk("pullup", 16'h0000, 16'(cfg_pullup_en));
      chk("bus_cfg", eb, first_bus_config_reg);
      chk("cs_en", 16'(cs_tab[es[2:1]]), 16'(chip_select_en));
      chk("seg_en", 16'(seg_tab[es[4:3]]), 16'(segment_line_en));
      chk("mult", 16'(mult_tab[es[7:5]]), 16'(clk_mult_x2));
      chk("bus16", 16'(eb[7]), 16'(bus_is_16bit));
      chk("muxed", 16'(eb[6]), 16'(bus_is_muxed));
   endtask
   task automatic reset_seq(input logic [7:0] sb, input logic [1:0] b, input logic e,
      input logic l);
      @(posedge clk);
      pd_mask <= {~sb, ~b, 6'h00};
      external_access_pin <= e;
      long_rst <= l;
      rst_seq <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk("pullup_seq", 16'h0001, 16'(cfg_pullup_en));
      @(posedge clk);
      rst_seq <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   // ==========================================
   // read data watcher
   always @(posedge clk) begin
      rd_seen <= rd_en;
   end
   always @(negedge clk) begin
      if (rd_seen === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("rdata_unexpected", 16'h0000, 16'hffff);
         end else begin
            chk("rdata", exp_q.pop_front(), rdata);
         end
      end else begin
         chk("rdata_idle", 16'h0000, rdata);
      end
   end
   // ==========================================
   // watchdog
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      end_sim();
   end
   // ==========================================
   // main sequence
   initial begin
      {rst_b, rst_seq, long_rst, external_access_pin, wr_en, rd_en} = '0;
      {wr_strobe_b, byte_hi_b, low_b, high_b} = 4'hf;
      {addr, wdata, pd_mask} = '0;
      void'($urandom(32'h9a98));
      repeat (20) @(posedge clk);
      #1 chk("strap_rst", 16'h00ff, 16'(reset_strap_config));
      chk("bus_cfg_rst", 16'h0000, first_bus_config_reg);
      @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      #1 check_cfg(8'hff, 16'h06c0);
      exp_s = 8'hff;
      // rounds 8 and 9 run short, so the clock field must stay at 111
      for (int i = 0; i < 10; i++) begin
         c = 3'(i);
         s = {c, c[1:0], ~c[1:0], c[0]};
         bt = 2'($urandom);
         // first two rounds pin both levels of the external-access pin
         w[0] = (i < 2) ? 1'(i) : 1'($urandom);
         reset_seq(s, bt, w[0], i < 8);
         exp_s = (i < 8) ? s : {exp_s[7:5], s[4:0]};
         check_cfg(exp_s, w[0] ? 16'h0000 : (16'h0600 | {8'h00, bt, 6'h00}));
         for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            st = 4'($urandom);
            {wr_strobe_b, byte_hi_b, low_b, high_b} <= st;
            @(posedge clk);
            #1 chk("write_pin", 16'(s[0] ? st[3] : st[1]), 16'(write_pin_b));
            chk("bhe_pin", 16'(s[0] ? st[2] : st[0]), 16'(byte_high_enable_pin_b));
         end
      end
      w = 16'($urandom);
      acc(1'b1, 1'b0, STRAP_CFG_OFFSET, w);
      acc(1'b0, 1'b1, STRAP_CFG_OFFSET, {8'h00, exp_s});
      acc(1'b1, 1'b0, BUS_CFG_OFFSET, w);
      acc(1'b0, 1'b1, BUS_CFG_OFFSET, w);
      acc(1'b0, 1'b1, 16'hf10a, 16'h0000);
      acc(1'b0, 1'b1, STRAP_CFG_OFFSET, {8'h00, exp_s});
      acc(1'b0, 1'b0, 16'h0000, 16'h0000);
      repeat (3) @(posedge clk);
      #1 chk("bus16_sw", 16'(w[7]), 16'(bus_is_16bit));
      chk("muxed_sw", 16'(w[6]), 16'(bus_is_muxed));
      end_sim();
   end
endmodule
